/* src/eccp_unit.v */
// Contract
// - up to four pwm output pins
// - capture/compare timers 1/3, pwm timers 2/4
// - timer pair chosen by select bit
// - capture copies selected 16-bit timer count
// - capture edge chosen by mode field
// - capture sets flag; software clears it
// - new capture overwrites old value
// - port write may trigger capture
// - prescaler cleared when off or leaving capture
// - prescaler switch keeps counter
// - compare match drives, clears, toggles pin; flags
// - control write zero clears compare latch
// - mode 1010 sets flag only
// - mode 1011 resets time base timer
// - special event starts converter when enabled
// - ten-bit pwm, four output arrangements
// - arrangement codes 00,10,01,11
// - steering enables pick single-mode outputs
// - mode low bits set polarity
// - pwm waits for new period
// - unused pwm pins: A falls back to port latch, B-D driven low
// - mode 0000 turns unit off, resets
// - mode 0010 toggles pin on match
// - forward: D modulated, A active
// - half-bridge: A,B complementary; C,D driven low
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`include "eccp_map.vh"
`default_nettype none
module eccp_unit (
    // ahb-lite slave
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    // timer sources
    input wire [15:0] first_timer_count,
    input wire [15:0] third_timer_count,
    input wire [7:0] second_timer_count,
    input wire [7:0] fourth_timer_count,
    input wire [1:0] second_timer_phase,
    input wire [1:0] fourth_timer_phase,
    // timer and converter triggers
    output reg first_timer_reset,
    output reg third_timer_reset,
    output reg adc_start,
    input wire adc_enabled,
    // pins
    input wire unit_primary_pin_in,
    output reg pwm_output_a,
    output reg pwm_output_b,
    output reg pwm_output_c,
    output reg pwm_output_d,
    output wire [3:0] pwm_output_en,
    // interrupt flag level toward the interrupt controller
    output wire unit_interrupt_flag
);
    reg [7:0] unit_control_register_q;
    reg [15:0] capture_compare_word_q;
    reg [7:0] period_q;
    reg [9:0] duty_latch_q;
    reg flag_q;
    reg tsel_q;
    reg [3:0] steer_q;
    reg port_latch_q;
    reg [3:0] pin_direction_bits_q;
    reg cmp_latch_q;
    reg [3:0] ps_cnt_q;
    reg pin_s1_q;
    reg pin_s2_q;
    reg pin_prev_q;
    reg match_prev_q;
    reg pwm_run_q;
    reg pwm_hi_q;
    reg [7:0] tmr_prev_q;
    // bus address phase capture
    reg wr_q;
    reg rd_q;
    reg [11:0] addr_q;
    reg [31:0] rdata_q;

    wire [3:0] mode = unit_control_register_q[`ECCP_MODE_HI:`ECCP_MODE_LO];
    wire [1:0] arr = unit_control_register_q[`ECCP_ARR_HI:`ECCP_ARR_LO];
    wire is_cap = (mode[3:2] == 2'h1);
    wire is_cmp = (mode == `ECCP_M_CMP_TOG) || (mode[3:2] == 2'h2);
    wire is_pwm = (mode[3:2] == 2'h3);
    wire acc = hsel && hready && htrans[1];

    wire [15:0] cc_timer = tsel_q ? third_timer_count : first_timer_count;
    wire [7:0] pw_timer = tsel_q ? fourth_timer_count : second_timer_count;
    wire [1:0] pw_phase = tsel_q ? fourth_timer_phase : second_timer_phase;

    // pin direction output selects capture source from port latch
    wire pin_is_out = pin_direction_bits_q[0];
    wire pin_level = pin_is_out ? port_latch_q : pin_s2_q;
    wire rise = pin_level && !pin_prev_q;
    wire fall = !pin_level && pin_prev_q;

    reg cap_evt;
    always @*
    begin
        cap_evt = 1'b0;
        case (mode)
            `ECCP_M_CAP_FALL: cap_evt = fall;
            `ECCP_M_CAP_RISE: cap_evt = rise;
            `ECCP_M_CAP_R4: cap_evt = rise && (ps_cnt_q[1:0] == `ECCP_PS_4);
            `ECCP_M_CAP_R16: cap_evt = rise && (ps_cnt_q == `ECCP_PS_16);
            default: cap_evt = 1'b0;
        endcase
    end

    wire eq = (capture_compare_word_q == cc_timer);
    wire cmp_evt = is_cmp && eq && !match_prev_q;
    wire set_flag = (is_cap && cap_evt) || cmp_evt;
    wire wr_ctrl = wr_q && (addr_q == `ECCP_ADDR_CTRL);
    wire wr_flag = wr_q && (addr_q == `ECCP_ADDR_FLAG);
    wire wr_port = wr_q && (addr_q == `ECCP_ADDR_PORT);

    // period boundary: timer first reaches period
    wire period_end = (pw_timer == period_q) && (tmr_prev_q != period_q);
    wire [9:0] pw_now = {pw_timer, pw_phase};

    // ahb bus slave, zero wait states
    assign hreadyout = 1'b1;
    assign hresp = `ECCP_HRESP_OKAY;
    assign hrdata = rdata_q;
    assign unit_interrupt_flag = flag_q;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 12'h000;
        end
        else if (hready)
        begin
            wr_q <= acc && hwrite;
            rd_q <= acc && !hwrite;
            addr_q <= {haddr[11:2], 2'h0};
        end
    end

    always @*
    begin
        rdata_q = 32'h00000000;
        if (!rd_q)
            rdata_q = 32'h00000000;
        else if (addr_q == `ECCP_ADDR_CTRL)
            rdata_q = {24'h000000, unit_control_register_q};
        else if (addr_q == `ECCP_ADDR_WORD)
            rdata_q = {16'h0000, is_pwm ? {duty_latch_q[9:2], capture_compare_word_q[7:0]}
                                        : capture_compare_word_q};
        else if (addr_q == `ECCP_ADDR_FLAG)
            rdata_q = {31'h0, flag_q};
        else if (addr_q == `ECCP_ADDR_TSEL)
            rdata_q = {31'h0, tsel_q};
        else if (addr_q == `ECCP_ADDR_STEER)
            rdata_q = {28'h0000000, steer_q};
        else if (addr_q == `ECCP_ADDR_PERIOD)
            rdata_q = {24'h000000, period_q};
        else if (addr_q == `ECCP_ADDR_PORT)
            rdata_q = {31'h0, port_latch_q};
        else if (addr_q == `ECCP_ADDR_DIR)
            rdata_q = {28'h0000000, pin_direction_bits_q};
        else if (addr_q == `ECCP_ADDR_STATUS)
            rdata_q = {29'h0, pwm_run_q, cmp_latch_q, pin_level};
        else
            rdata_q = 32'h00000000;
    end

    // register writes and core state
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            unit_control_register_q <= 8'h00;
            capture_compare_word_q <= 16'h0000;
            period_q <= `ECCP_PERIOD_RST;
            duty_latch_q <= 10'h000;
            flag_q <= 1'b0;
            tsel_q <= 1'b0;
            steer_q <= `ECCP_STEER_RST;
            port_latch_q <= 1'b0;
            pin_direction_bits_q <= 4'h0;
            cmp_latch_q <= 1'b0;
            ps_cnt_q <= 4'h0;
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_prev_q <= 1'b0;
            match_prev_q <= 1'b0;
            pwm_run_q <= 1'b0;
            pwm_hi_q <= 1'b0;
            tmr_prev_q <= 8'h00;
        end
        else
        begin
            pin_s1_q <= unit_primary_pin_in;
            pin_s2_q <= pin_s1_q;
            pin_prev_q <= pin_level;
            match_prev_q <= is_cmp && eq;
            tmr_prev_q <= pw_timer;
            if (wr_ctrl)
                unit_control_register_q <= hwdata[7:0];
            if (wr_q && addr_q == `ECCP_ADDR_TSEL)
                tsel_q <= hwdata[0];
            if (wr_q && addr_q == `ECCP_ADDR_STEER)
                steer_q <= hwdata[3:0];
            if (wr_q && addr_q == `ECCP_ADDR_PERIOD)
                period_q <= hwdata[7:0];
            if (wr_port)
                port_latch_q <= hwdata[0];
            if (wr_q && addr_q == `ECCP_ADDR_DIR)
                pin_direction_bits_q <= hwdata[3:0];
            // capture load overrides a software write to the word
            if (is_cap && cap_evt)
                capture_compare_word_q <= cc_timer;
            else if (wr_q && addr_q == `ECCP_ADDR_WORD)
                capture_compare_word_q <= hwdata[15:0];
            // hardware set wins over software clear
            if (set_flag)
                flag_q <= 1'b1;
            else if (wr_flag && !hwdata[0])
                flag_q <= 1'b0;
            // prescaler: off or outside capture clears; switching keeps count
            if (!is_cap)
                ps_cnt_q <= 4'h0;
            else if (rise)
                ps_cnt_q <= ps_cnt_q + 4'h1;
            // compare output latch
            if (wr_ctrl && hwdata[7:0] == 8'h00)
                cmp_latch_q <= 1'b0;
            else if (wr_ctrl && hwdata[3:0] == `ECCP_M_CMP_SET)
                cmp_latch_q <= 1'b0;
            else if (wr_ctrl && hwdata[3:0] == `ECCP_M_CMP_CLR)
                cmp_latch_q <= 1'b1;
            else if (cmp_evt)
            begin
                case (mode)
                    `ECCP_M_CMP_TOG: cmp_latch_q <= !cmp_latch_q;
                    `ECCP_M_CMP_SET: cmp_latch_q <= 1'b1;
                    `ECCP_M_CMP_CLR: cmp_latch_q <= 1'b0;
                    default: cmp_latch_q <= cmp_latch_q;
                endcase
            end
            // pwm: start only at a period boundary
            if (!is_pwm)
                pwm_run_q <= 1'b0;
            else if (period_end)
                pwm_run_q <= 1'b1;
            if (period_end)
            begin
                duty_latch_q <= {capture_compare_word_q[7:0],
                                 unit_control_register_q[`ECCP_DCL_HI:`ECCP_DCL_LO]};
                pwm_hi_q <= is_pwm;
            end
            else if (pw_now == duty_latch_q)
                pwm_hi_q <= 1'b0;
        end
    end

    // special event trigger pulses
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            first_timer_reset <= 1'b0;
            third_timer_reset <= 1'b0;
            adc_start <= 1'b0;
        end
        else
        begin
            first_timer_reset <= cmp_evt && mode == `ECCP_M_CMP_SPEV && !tsel_q;
            third_timer_reset <= cmp_evt && mode == `ECCP_M_CMP_SPEV && tsel_q;
            adc_start <= cmp_evt && mode == `ECCP_M_CMP_SPEV && adc_enabled;
        end
    end

    // output arrangement, polarity and pin ownership
    wire wave = pwm_run_q && pwm_hi_q;
    reg [3:0] act;
    reg [3:0] own;
    always @*
    begin
        act = 4'h0;
        own = 4'h1;
        if (is_pwm)
        begin
            case (arr)
                `ECCP_ARR_SINGLE:
                begin
                    act = {4{wave}} & steer_q;
                    own = steer_q;
                end
                `ECCP_ARR_HALF:
                begin
                    act = {2'h0, !wave && pwm_run_q, wave};
                    own = 4'h3;
                end
                `ECCP_ARR_FWD:
                begin
                    act = {wave, 2'h0, pwm_run_q};
                    own = 4'hF;
                end
                default:
                begin
                    act = {1'b0, pwm_run_q, wave, 1'b0};
                    own = 4'hF;
                end
            endcase
        end
        else
            act = {3'h0, cmp_latch_q};
    end

    // pin a not owned falls back to port latch, b-d drive low; direction bits gate drivers
    wire [3:0] pol = is_pwm ? {mode[0], mode[1], mode[0], mode[1]} : 4'h0;
    assign pwm_output_en = pin_direction_bits_q;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pwm_output_a <= 1'b0;
            pwm_output_b <= 1'b0;
            pwm_output_c <= 1'b0;
            pwm_output_d <= 1'b0;
        end
        else
        begin
            // capture, software-interrupt and off modes leave pin to port latch
            pwm_output_a <= (own[0] && (is_pwm || (is_cmp && mode != `ECCP_M_CMP_SW
                             && mode != `ECCP_M_CMP_SPEV))) ? act[0] ^ pol[0]
                            : port_latch_q;
            pwm_output_b <= own[1] && is_pwm ? act[1] ^ pol[1] : 1'b0;
            pwm_output_c <= own[2] && is_pwm ? act[2] ^ pol[2] : 1'b0;
            pwm_output_d <= own[3] && is_pwm ? act[3] ^ pol[3] : 1'b0;
        end
    end
endmodule // eccp_unit
`default_nettype wire

/* src/eccp_map.vh */
`ifndef ECCP_MAP_VH
`define ECCP_MAP_VH
// register byte addresses
`define ECCP_ADDR_CTRL      12'h000
`define ECCP_ADDR_WORD      12'h004
`define ECCP_ADDR_FLAG      12'h008
`define ECCP_ADDR_TSEL      12'h00C
`define ECCP_ADDR_STEER     12'h010
`define ECCP_ADDR_PERIOD    12'h014
`define ECCP_ADDR_PORT      12'h018
`define ECCP_ADDR_DIR       12'h01C
`define ECCP_ADDR_STATUS    12'h020
// control register fields
`define ECCP_ARR_HI         7
`define ECCP_ARR_LO         6
`define ECCP_DCL_HI         5
`define ECCP_DCL_LO         4
`define ECCP_MODE_HI        3
`define ECCP_MODE_LO        0
// mode codes
`define ECCP_M_OFF          4'h0
`define ECCP_M_CMP_TOG      4'h2
`define ECCP_M_CAP_FALL     4'h4
`define ECCP_M_CAP_RISE     4'h5
`define ECCP_M_CAP_R4       4'h6
`define ECCP_M_CAP_R16      4'h7
`define ECCP_M_CMP_SET      4'h8
`define ECCP_M_CMP_CLR      4'h9
`define ECCP_M_CMP_SW       4'hA
`define ECCP_M_CMP_SPEV     4'hB
// arrangement codes
`define ECCP_ARR_SINGLE     2'h0
`define ECCP_ARR_FWD        2'h1
`define ECCP_ARR_HALF       2'h2
`define ECCP_ARR_REV        2'h3
// prescaler terminal counts
`define ECCP_PS_4           2'h3
`define ECCP_PS_16          4'hF
// reset values and bus response code
`define ECCP_PERIOD_RST     8'hFF
`define ECCP_STEER_RST      4'h1
`define ECCP_HRESP_OKAY     1'b0
`endif

/* testbench/eccp_unit_asserts.sv */
`default_nettype none
module eccp_unit_asserts (
    // bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // triggers, pins, flag
    input wire logic first_timer_reset,
    input wire logic third_timer_reset,
    input wire logic adc_start,
    input wire logic adc_enabled,
    input wire logic [3:0] pwm_output_en,
    input wire logic unit_interrupt_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_q;
    logic rd_q;
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // data phase of a write or read taken on the bus
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end
        else
        begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            rd_q <= hsel && hready && htrans[1] && !hwrite;
        end
    end
    sequence one_pulse(s);
        s ##1 !s;
    endsequence
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    rdata_idle_a: assert property (!rd_q && !wr_q |-> hrdata == 32'h0)
        else $error("read data outside data phase");
    flag_clear_a: assert property ($fell(unit_interrupt_flag) |-> $past(wr_q))
        else $error("flag cleared without a write");
    en_change_a: assert property ($changed(pwm_output_en) |-> $past(wr_q))
        else $error("output enables changed without a write");
    spev_one_a: assert property (
        $rose(first_timer_reset) |-> one_pulse(first_timer_reset))
        else $error("first timer reset not one cycle");
    spev_three_a: assert property (
        $rose(third_timer_reset) |-> one_pulse(third_timer_reset))
        else $error("third timer reset not one cycle");
    trig_excl_a: assert property (!(first_timer_reset && third_timer_reset))
        else $error("both timers reset");
    adc_gate_a: assert property (
        adc_start |-> $past(adc_enabled) && (first_timer_reset || third_timer_reset))
        else $error("converter start without trigger");
    trig_flag_a: assert property (
        first_timer_reset || third_timer_reset |-> unit_interrupt_flag)
        else $error("trigger without flag");
endmodule // eccp_unit_asserts
`default_nettype wire

/* testbench/eccp_timer_model.sv */
`default_nettype none
module eccp_timer_model #(
    parameter logic [7:0] PERIOD = 8'h09
) (
    // clock and triggers
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic first_timer_reset,
    input wire logic third_timer_reset,
    // counts
    output var logic [15:0] first_timer_count,
    output var logic [15:0] third_timer_count,
    output var logic [7:0] second_timer_count,
    output var logic [1:0] second_timer_phase
);
    timeunit 1ns;
    timeprecision 1ps;
    // counts advance on hclk only, never asynchronously
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            first_timer_count <= 16'h0000;
            third_timer_count <= 16'h0100;
            second_timer_count <= 8'h00;
            second_timer_phase <= 2'h0;
        end
        else
        begin
            if (first_timer_reset)
                first_timer_count <= 16'h0000;
            else if (run)
                first_timer_count <= first_timer_count + 16'h0001;
            if (third_timer_reset)
                third_timer_count <= 16'h0000;
            else if (run)
                third_timer_count <= third_timer_count + 16'h0001;
            second_timer_phase <= second_timer_phase + 2'h1;
            if (second_timer_phase == 2'h3)
            begin
                if (second_timer_count == PERIOD)
                    second_timer_count <= 8'h00;
                else
                    second_timer_count <= second_timer_count + 8'h01;
            end
        end
    end
endmodule // eccp_timer_model
`default_nettype wire

/* testbench/eccp_unit_tb_top.sv */
`include "eccp_map.vh"
`default_nettype none
module eccp_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic run = 1'b0;
    logic adc_enabled = 1'b0;
    logic pin = 1'b0;
    logic [31:0] rd_smp;
    logic rdy_smp;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, first_timer_reset, third_timer_reset, adc_start;
    wire logic unit_interrupt_flag, pa, pb, pc, pd;
    wire logic [3:0] pwm_output_en;
    wire logic [15:0] t1, t3;
    wire logic [7:0] t2;
    wire logic [1:0] t2p;
    int error_cnt = 0, n_tests = 0, cyc = 0, n_r1 = 0, n_r3 = 0, n_adc = 0;
    eccp_unit u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .first_timer_count(t1),
        .third_timer_count(t3), .second_timer_count(t2), .fourth_timer_count(8'h00),
        .second_timer_phase(t2p), .fourth_timer_phase(2'h0), .first_timer_reset,
        .third_timer_reset, .adc_start, .adc_enabled, .unit_primary_pin_in(pin),
        .pwm_output_a(pa), .pwm_output_b(pb), .pwm_output_c(pc), .pwm_output_d(pd),
        .pwm_output_en, .unit_interrupt_flag);
    eccp_timer_model #(.PERIOD(8'h09)) u_tmr (.hclk, .hresetn, .run, .first_timer_reset,
        .third_timer_reset, .first_timer_count(t1), .third_timer_count(t3),
        .second_timer_count(t2), .second_timer_phase(t2p));
    initial
        forever #5 hclk = ~hclk;
    always @(posedge hclk)
    begin
        rd_smp <= hrdata;
        rdy_smp <= hreadyout;
        cyc <= cyc + 1;
        n_r1 <= n_r1 + int'(first_timer_reset);
        n_r3 <= n_r3 + int'(third_timer_reset);
        n_adc <= n_adc + int'(adc_start);
        if (cyc == 20000)
        begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    task automatic rdy;
        tick(1);
        while (rdy_smp !== 1'b1)
            tick(1);
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        rdy();
        r = rd_smp;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, e, n);
    endtask
    task automatic pulse;
        pin <= 1'b1;
        tick(5);
        pin <= 1'b0;
        tick(5);
    endtask
    task automatic wait_flag;
        int n;
        n = 0;
        while (unit_interrupt_flag !== 1'b1 && n < 300)
        begin
            tick(1);
            n++;
        end
        chk(unit_interrupt_flag, 1'b1, "match flag");
    endtask
    task automatic t_regs;
        rd(`ECCP_ADDR_STEER, 32'h1, "steer reset");
        rd(`ECCP_ADDR_PERIOD, 32'hFF, "period reset");
        rd(`ECCP_ADDR_FLAG, 32'h0, "flag reset");
        wr(12'h0FC, 32'hFFFFFFFF);
        rd(12'h0FC, 32'h0, "unmapped");
        wr(`ECCP_ADDR_CTRL, 32'hC5);
        rd(`ECCP_ADDR_CTRL, 32'hC5, "ctrl rw");
        $display("regs test done");
    endtask
    task automatic t_capture;
        logic [3:0] md [4] = '{4'h5, 4'h4, 4'h6, 4'h7};
        int ne [4] = '{1, 1, 4, 16};
        logic [15:0] tv;
        for (int i = 0; i < 4; i++)
        begin
            wr(`ECCP_ADDR_CTRL, 32'h0);
            wr(`ECCP_ADDR_CTRL, {28'h0, md[i]});
            for (int r = 0; r < 2; r++)
            begin
                wr(`ECCP_ADDR_FLAG, 32'h0);
                run <= 1'b1;
                tick(7 + r);
                run <= 1'b0;
                tick(1);
                tv = t1;
                for (int k = 1; k <= ne[i]; k++)
                begin
                    pulse();
                    chk(unit_interrupt_flag, k == ne[i], "capture flag");
                end
            end
            rd(`ECCP_ADDR_WORD, {16'h0, tv}, "capture word");
        end
        wr(`ECCP_ADDR_CTRL, 32'h0);
        wr(`ECCP_ADDR_CTRL, 32'h5);
        wr(`ECCP_ADDR_DIR, 32'h1);
        wr(`ECCP_ADDR_FLAG, 32'h0);
        wr(`ECCP_ADDR_PORT, 32'h1);
        tick(5);
        chk(unit_interrupt_flag, 1'b1, "port capture");
        wr(`ECCP_ADDR_PORT, 32'h0);
        $display("capture test done");
    endtask
    task automatic t_compare;
        logic [3:0] md [4] = '{4'h8, 4'h9, 4'h2, 4'hA};
        logic ex [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
        run <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            wr(`ECCP_ADDR_CTRL, 32'h0);
            rd(`ECCP_ADDR_STATUS, 32'h0, "latch cleared");
            // software-interrupt mode must leave the pin on the port latch
            if (i == 3)
                wr(`ECCP_ADDR_PORT, 32'h1);
            wr(`ECCP_ADDR_FLAG, 32'h0);
            wr(`ECCP_ADDR_WORD, {16'h0, t1 + 16'h0028});
            wr(`ECCP_ADDR_CTRL, {28'h0, md[i]});
            wait_flag();
            tick(3);
            chk(pa, ex[i], "compare pin");
        end
        wr(`ECCP_ADDR_PORT, 32'h0);
        for (int j = 0; j < 3; j++)
        begin
            int a1, a3, aa;
            wr(`ECCP_ADDR_CTRL, 32'h0);
            wr(`ECCP_ADDR_TSEL, {31'h0, j == 1});
            adc_enabled <= j != 2;
            wr(`ECCP_ADDR_FLAG, 32'h0);
            wr(`ECCP_ADDR_WORD, {16'h0, (j == 1 ? t3 : t1) + 16'h0028});
            a1 = n_r1;
            a3 = n_r3;
            aa = n_adc;
            wr(`ECCP_ADDR_CTRL, 32'hB);
            wait_flag();
            tick(2);
            chk(n_r1 - a1, j != 1, "first reset");
            chk(n_r3 - a3, j == 1, "third reset");
            chk(n_adc - aa, j != 2, "adc start");
        end
        wr(`ECCP_ADDR_CTRL, 32'h0);
        wr(`ECCP_ADDR_TSEL, 32'h0);
        $display("compare test done");
    endtask
    task automatic t_pwm;
        logic [13:0] cfg [5] = '{14'h0CE0, 14'h1C71, 14'h3CD4, 14'h2CC0, 14'h1F76};
        logic [3:0] s1, s0, o, cm;
        logic bad;
        wr(`ECCP_ADDR_PERIOD, 32'h9);
        wr(`ECCP_ADDR_DIR, 32'hF);
        wr(`ECCP_ADDR_WORD, 32'h4);
        for (int i = 0; i < 5; i++)
        begin
            wr(`ECCP_ADDR_CTRL, 32'h0);
            wr(`ECCP_ADDR_CTRL, {24'h0, cfg[i][13:12], 2'b00, cfg[i][11:8]});
            tick(50);
            cm = cfg[i][7:4];
            s1 = 4'h0;
            s0 = 4'h0;
            bad = 1'b0;
            repeat (80)
            begin
                o = {pd, pc, pb, pa};
                s1 |= o;
                s0 |= ~o;
                bad |= cfg[i][13:12] == 2'h2 && pa === pb;
                tick(1);
            end
            chk(s1 & cm, cfg[i][3:0], "pwm active");
            chk(s0 & cm, cm & ~cfg[i][3:0], "pwm idle");
            chk(s1 & s0, cm ^ 4'hF, "pwm modulated");
            chk(bad, 1'b0, "half complement");
        end
        // fourth timer is held at zero: with it selected no period ever starts
        wr(`ECCP_ADDR_CTRL, 32'h0);
        wr(`ECCP_ADDR_TSEL, 32'h1);
        wr(`ECCP_ADDR_CTRL, 32'hC);
        s1 = 4'h0;
        repeat (60)
        begin
            s1 |= {pd, pc, pb, pa};
            tick(1);
        end
        chk(s1, 4'h0, "fourth timer idle");
        wr(`ECCP_ADDR_TSEL, 32'h0);
        chk(pwm_output_en, 4'hF, "drive enables");
        wr(`ECCP_ADDR_CTRL, 32'h0);
        $display("pwm test done");
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        tick(1);
        t_regs();
        t_capture();
        t_compare();
        t_pwm();
        stop_test();
    end
endmodule // eccp_unit_tb_top
bind eccp_unit eccp_unit_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hrdata, .hreadyout, .hresp, .first_timer_reset, .third_timer_reset, .adc_start,
    .adc_enabled, .pwm_output_en, .unit_interrupt_flag);
`default_nettype wire
